// File: rtl/spi_cfg_pkg.sv
// Purpose: Shared constants for the serial port configuration unit
// Assumes: Byte-wide special function register bus
// Notes:   Clock-rate register is not part of this unit
package spi_cfg_pkg;
  localparam logic [7:0] CFG_ADDR     = 8'hA1;
  localparam logic [7:0] CFG_RESET    = 8'h07;
  localparam int         BUSY_BIT     = 7;
  localparam int         MASTER_ROLE_ENABLE_BIT    = 6;
  localparam int         PHASE_BIT    = 5;
  localparam int         POL_BIT      = 4;
  localparam int         SLAVE_SELECTED_FLAG_BIT   = 3;
  localparam int         PINLVL_BIT   = 2;
  localparam int         SHIFT_REGISTER_EMPTY_BIT     = 1;
  localparam int         RECEIVE_BUFFER_EMPTY_BIT    = 0;
  localparam int         CLK_HZ       = 10_000_000;
  localparam int         SCK_HALF_NS  = 200;
  localparam int         HALF_CYC     = (SCK_HALF_NS * (CLK_HZ / 1_000_000)
                                         + 999) / 1000;
  localparam logic [3:0] HALF_CNT     = 4'(HALF_CYC);
  localparam logic [3:0] BIT_LAST     = 4'(2 * HALF_CYC - 1);
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [7:0] IDLE_FILL    = 8'hFF;
  typedef enum logic [1:0] {
    M_IDLE = 2'b01,
    M_RUN  = 2'b10
  } mstate_t;
endpackage

// File: rtl/spi_config_status_unit.sv
// Purpose: Configuration/status register of a serial peripheral port,
//          with the shift engine whose state the register reports
// Assumes: Slave link clock stops outside frames; config static in frames
// Notes:   Data and control registers are reduced to plain ports
// Overview of operation
// [RULE_01] Busy reads 1 while a transfer runs in either role, else 0. As slave the code returns the slave-selected flag instead.
// [RULE_02] The master-enable bit picks slave (0) or master (1) role.
// [RULE_03] Phase 0 centres data on the first clock edge, 1 on the second.
// [RULE_04] Polarity 0 idles the serial clock low, 1 idles it high.
// [RULE_05] Slave-selected reads 1 while the select input is low.
// [RULE_06] Slave-selected comes from a de-glitched copy of the select.
// [RULE_07] Pin-level bit returns the select level at read time.
// [RULE_08] Shift-empty is set when nothing is queued; 1 in master role.
// [RULE_09] Shift-empty clears when a byte moves in or out of the shifter.
// [RULE_10] Receive-empty is 0 while unread data waits; 1 in master role.
// [RULE_11] As slave, incoming data is sampled at the bit centre.
// [RULE_12] As master, input is sampled one cycle before the bit ends.
// [RULE_13] Software sees the port through a configuration register.
// [RULE_14] Writes to the read-only status bits have no effect.
// [RULE_15] A far master lowers select first and matches phase/polarity.
`timescale 1ns/100ps
`default_nettype none
module spi_config_status_unit (
  input  wire logic       REF_CLK,
  input  wire logic       RESET,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  output logic      [7:0] SFR_RDATA,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_WR,
  output logic            TX_READY,
  output logic      [7:0] RX_DATA,
  input  wire logic       RX_READ,
  input  wire logic       SCK_I,
  output logic            SCK_O,
  output logic            SCK_OE,
  input  wire logic       MOSI_I,
  output logic            MOSI_O,
  output logic            MOSI_OE,
  input  wire logic       MISO_I,
  output logic            MISO_O,
  output logic            MISO_OE,
  input  wire logic       SELECT_N
);
  // Configuration and pin synchronisers
  logic [2:0] cfg_q, cfg_d;
  logic [2:0] sel_q, sel_d, miso_q, miso_d, rtg_q, rtg_d, ttg_q, ttg_d;
  logic       slave_selected_flag_q, slave_selected_flag_d;
  logic [7:0] rdata_q, rdata_d;
  logic       master, phase, pol, busy, shift_register_empty, receive_buffer_empty;
  logic [7:0] status;

  assign master = cfg_q[2]; // see [RULE_02]
  assign phase  = cfg_q[1];
  assign pol    = cfg_q[0];

  // Address decode shared by read and write paths
  function automatic logic cfg_hit(input logic [7:0] a);
    return a == spi_cfg_pkg::CFG_ADDR;
  endfunction

  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = rdata_q;
    if (SFR_WR && cfg_hit(SFR_ADDR)) begin
      // Only role, phase, polarity take writes; see [RULE_14]
      cfg_d = SFR_WDATA[spi_cfg_pkg::MASTER_ROLE_ENABLE_BIT:spi_cfg_pkg::POL_BIT];
    end
    if (SFR_RD && cfg_hit(SFR_ADDR)) begin
      rdata_d = status; // see [RULE_13]
    end
    sel_d  = {sel_q[1:0], SELECT_N};
    miso_d = {miso_q[1:0], MISO_I};
    slave_selected_flag_d = slave_selected_flag_q;
    // Level accepted only when stages two and three agree
    if (sel_q[1] == sel_q[2]) begin
      slave_selected_flag_d = ~sel_q[2]; // see [RULE_05] see [RULE_06]
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cfg_q    <= 3'h0;
      rdata_q  <= spi_cfg_pkg::CFG_RESET;
      sel_q    <= 3'h7;
      miso_q   <= 3'h0;
      slave_selected_flag_q <= 1'b0;
    end else begin
      cfg_q    <= cfg_d;
      rdata_q  <= rdata_d;
      sel_q    <= sel_d;
      miso_q   <= miso_d;
      slave_selected_flag_q <= slave_selected_flag_d;
    end
  end

  // Event toggles from the link domain
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rtg_q <= 3'h0;
      ttg_q <= 3'h0;
    end else begin
      rtg_q <= rtg_d;
      ttg_q <= ttg_d;
    end
  end

  // Slave link domain; clock folded so sampling is always its rise
  logic       lsck;
  logic [2:0] lcnt_q, lcnt_d;
  logic [7:0] lsh_q, lsh_d, lrx_q, lrx_d;
  logic       lrt_q, lrt_d, ltt_q, ltt_d, lout_q, lout_d;
  logic [7:0] tx_hold_q, tx_hold_d;
  logic       lsel;

  // Phase 1 samples on the second edge; see [RULE_03] see [RULE_04]
  assign lsck = SCK_I ^ pol ^ phase;
  assign lsel = SELECT_N | master;

  always_comb begin
    lcnt_d = lcnt_q + 3'h1;
    lsh_d  = {lsh_q[6:0], MOSI_I}; // Bit centre sample; see [RULE_11]
    lrx_d  = lrx_q;
    lrt_d  = lrt_q;
    ltt_d  = ltt_q;
    if (lcnt_q == 3'h0) begin
      // Byte leaves the transmit buffer; see [RULE_09]
      // Hold byte crosses unsynchronised; load it only between frames
      lsh_d = {tx_hold_q[6:0], MOSI_I};
      // Clock edges outside a frame must not count as a taken byte
      if (!lsel) begin
        ltt_d = ~ltt_q;
      end
    end
    if (lcnt_q == spi_cfg_pkg::LAST_BIT) begin
      lrx_d = lsh_d;
      lrt_d = ~lrt_q;
    end
  end

  // Select high ends the frame and clears the count; see [RULE_15]
  always_ff @(posedge lsck or posedge lsel) begin
    if (lsel) begin
      lcnt_q <= 3'h0;
    end else begin
      lcnt_q <= lcnt_d;
    end
  end

  // Data path needs no reset: only read after a completed byte
  always_ff @(posedge lsck) begin
    lsh_q <= lsh_d;
    lrx_q <= lrx_d;
  end

  // Toggles must start known, else the event sync never settles
  always_ff @(posedge lsck or posedge RESET) begin
    if (RESET) begin
      lrt_q <= 1'b0;
      ltt_q <= 1'b0;
    end else begin
      lrt_q <= lrt_d;
      ltt_q <= ltt_d;
    end
  end

  // Output bit moves on the opposite edge to sampling
  always_comb begin
    lout_d = (lcnt_q == 3'h0) ? tx_hold_q[7] : lsh_q[7];
  end

  always_ff @(negedge lsck) begin
    lout_q <= lout_d;
  end

  // Toggles cross, so a short link event cannot be missed
  always_comb begin
    rtg_d = {rtg_q[1:0], lrt_q};
    ttg_d = {ttg_q[1:0], ltt_q};
  end

  // Master engine and buffers on the reference clock
  spi_cfg_pkg::mstate_t ms_q, ms_d;
  logic [3:0] div_q, div_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] msh_q, msh_d, rx_q, rx_d;
  logic       tx_full_q, tx_full_d, rx_full_q, rx_full_d;
  logic       mbusy, rx_evt, tx_evt, sck_hi;

  assign rx_evt = rtg_q[2] ^ rtg_q[1];
  assign tx_evt = ttg_q[2] ^ ttg_q[1];
  assign mbusy  = (ms_q == spi_cfg_pkg::M_RUN);

  always_comb begin
    ms_d      = ms_q;
    div_d     = div_q;
    bit_d     = bit_q;
    msh_d     = msh_q;
    rx_d      = rx_q;
    tx_hold_d = tx_hold_q;
    tx_full_d = tx_full_q;
    rx_full_d = rx_full_q;
    if (TX_WR && !tx_full_q) begin
      tx_hold_d = TX_DATA;
      tx_full_d = 1'b1;
    end
    if (RX_READ) begin
      rx_full_d = 1'b0;
    end
    if (!master && tx_evt) begin
      tx_full_d = 1'b0;
    end
    // Arrival wins over a read in the same cycle
    if (!master && rx_evt) begin
      rx_d      = lrx_q;
      rx_full_d = 1'b1;
    end
    unique case (ms_q)
      spi_cfg_pkg::M_IDLE: begin
        if (master && tx_full_q) begin
          msh_d     = tx_hold_q; // see [RULE_09]
          tx_full_d = 1'b0;
          div_d     = 4'h0;
          bit_d     = 3'h0;
          ms_d      = spi_cfg_pkg::M_RUN;
        end
      end
      spi_cfg_pkg::M_RUN: begin
        div_d = div_q + 4'h1;
        if (div_q == spi_cfg_pkg::BIT_LAST) begin
          // Late sample gives the slave most settling; see [RULE_12]
          msh_d = {msh_q[6:0], miso_q[2]};
          div_d = 4'h0;
          bit_d = bit_q + 3'h1;
          if (bit_q == spi_cfg_pkg::LAST_BIT) begin
            rx_d      = {msh_q[6:0], miso_q[2]};
            rx_full_d = 1'b1;
            ms_d      = spi_cfg_pkg::M_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ms_q      <= spi_cfg_pkg::M_IDLE;
      div_q     <= 4'h0;
      bit_q     <= 3'h0;
      msh_q     <= 8'h00;
      rx_q      <= 8'h00;
      tx_hold_q <= spi_cfg_pkg::IDLE_FILL;
      tx_full_q <= 1'b0;
      rx_full_q <= 1'b0;
    end else begin
      ms_q      <= ms_d;
      div_q     <= div_d;
      bit_q     <= bit_d;
      msh_q     <= msh_d;
      rx_q      <= rx_d;
      tx_hold_q <= tx_hold_d;
      tx_full_q <= tx_full_d;
      rx_full_q <= rx_full_d;
    end
  end

  // Status assembly
  always_comb begin
    // Slave busy follows select, as bytes may run back to back
    busy  = master ? mbusy : slave_selected_flag_q; // see [RULE_01]
    shift_register_empty  = master | (!tx_full_q && !slave_selected_flag_q); // see [RULE_08]
    receive_buffer_empty = master | !rx_full_q; // see [RULE_10]
    status = 8'h00;
    status[spi_cfg_pkg::BUSY_BIT]   = busy;
    status[spi_cfg_pkg::MASTER_ROLE_ENABLE_BIT]  = master;
    status[spi_cfg_pkg::PHASE_BIT]  = phase;
    status[spi_cfg_pkg::POL_BIT]    = pol;
    status[spi_cfg_pkg::SLAVE_SELECTED_FLAG_BIT] = slave_selected_flag_q;
    // Newest safe copy of the pin, no filtering; see [RULE_07]
    status[spi_cfg_pkg::PINLVL_BIT] = sel_q[1];
    status[spi_cfg_pkg::SHIFT_REGISTER_EMPTY_BIT]   = shift_register_empty;
    status[spi_cfg_pkg::RECEIVE_BUFFER_EMPTY_BIT]  = receive_buffer_empty;
  end

  // Clock level from bit position and phase; see [RULE_03]
  assign sck_hi = phase ? (div_q < spi_cfg_pkg::HALF_CNT)
                        : (div_q >= spi_cfg_pkg::HALF_CNT);

  assign SFR_RDATA = rdata_q;
  assign TX_READY  = !tx_full_q;
  assign RX_DATA   = rx_q;
  assign SCK_O     = pol ^ (mbusy & sck_hi); // see [RULE_04]
  assign SCK_OE    = master;
  assign MOSI_O    = msh_q[7];
  assign MOSI_OE   = master;
  assign MISO_O    = lout_q;
  assign MISO_OE   = !master && slave_selected_flag_q;
endmodule // spi_config_status_unit
`default_nettype wire

// File: tb/spi_cfg_props.sv
// Purpose: Port checks for the config unit
// Assumes: One system clock domain
// Notes:   Link traffic is judged by the bench
`timescale 1ns/100ps
`default_nettype none
module spi_cfg_props (
  input wire logic       REF_CLK,
  input wire logic       RESET,
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       TX_WR,
  input wire logic       TX_READY,
  input wire logic       SCK_OE,
  input wire logic       MOSI_OE,
  input wire logic       MISO_OE,
  input wire logic       SELECT_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  logic rd;
  assign rd = SFR_RD && SFR_ADDR == 8'hA1;
  a_reset_value: assert property ($fell(RESET) |-> SFR_RDATA == 8'h07)
    else $error("bad reset value");
  a_master_flags: assert property (rd |=> !SFR_RDATA[6] || SFR_RDATA[1:0] == 2'h3)
    else $error("empty flags low in master role");
  a_oe_exclusive: assert property (!(MOSI_OE && MISO_OE))
    else $error("both data lines driven");
  a_clock_data_oe: assert property (SCK_OE == MOSI_OE)
    else $error("clock and data enables differ");
  a_tx_taken: assert property (TX_WR && TX_READY |=> !TX_READY)
    else $error("byte not taken");
  a_rdata_hold: assert property (!rd |=> $stable(SFR_RDATA))
    else $error("read data moved");
  a_sel_flag: assert property (!SELECT_N [*6] ##0 rd |=> SFR_RDATA[3:2] == 2'h2)
    else $error("select flags wrong");
  a_desel_flag: assert property (SELECT_N [*6] ##0 rd |=> SFR_RDATA[3:2] == 2'h1)
    else $error("deselect flags wrong");
endmodule // spi_cfg_props
`default_nettype wire

// File: tb/spi_config_status_unit_test.sv
// Purpose: Register and link tests of the config unit
// Assumes: Far end in clock mode 0
// Notes:   Master rate is fixed, no rate register
`timescale 1ns/100ps
`default_nettype none
module spi_config_status_unit_test;
  logic ref_clk = 1'b0;
  logic lclk = 1'b0;
  logic reset = 1'b0;
  logic [7:0] addr = 8'hA1;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tx_wr = 1'b0;
  logic rx_read = 1'b0;
  logic [7:0] rdata, rx, got;
  logic tx_ready, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic sck, mosi, sel_n, miso;
  int fails = 0;
  int total_checks = 0;
  always #50 ref_clk = ~ref_clk;
  always #6 lclk = ~lclk;
  spi_config_status_unit spi_config_status_unit_inst (
    .REF_CLK(ref_clk), .RESET(reset), .SFR_ADDR(addr),
    .SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata),
    .TX_DATA(8'h5A), .TX_WR(tx_wr), .TX_READY(tx_ready),
    .RX_DATA(rx), .RX_READ(rx_read), .SCK_I(sck), .SCK_O(sck_o),
    .SCK_OE(sck_oe), .MOSI_I(mosi), .MOSI_O(mosi_o),
    .MOSI_OE(mosi_oe), .MISO_I(miso), .MISO_O(miso_o),
    .MISO_OE(miso_oe), .SELECT_N(sel_n));
  spi_far_end spi_far_end_inst (.lclk(lclk), .sck_m(sck_o),
    .mosi_m(mosi_o), .sck(sck), .mosi(mosi), .sel_n(sel_n),
    .miso(miso), .got(got));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, failures %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge ref_clk);
    wr = 1'b0;
  endtask
  task automatic rd_raw(input logic [7:0] a);
    @(negedge ref_clk);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk);
    rd = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    rd_raw(a);
    chk(rdata, exp);
  endtask
  initial begin
    #1 reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    rd_reg(8'hA1, 8'h07);
    wr_reg(8'hA1, 8'hFF);
    rd_reg(8'hA1, 8'h77);
    chk({7'h00, sck_o}, 8'h01);
    wr_reg(8'hA2, 8'h00);
    rd_reg(8'hA1, 8'h77);
    $display("Register test done");
    wr_reg(8'hA1, 8'h40);
    chk({7'h00, sck_o}, 8'h00);
    spi_far_end_inst.load(8'hC3);
    tx_wr = 1'b1;
    @(negedge ref_clk);
    tx_wr = 1'b0;
    chk({7'h00, tx_ready}, 8'h00);
    @(negedge ref_clk);
    rd_reg(8'hA1, 8'hC7);
    for (int n = 0; n < 80 && rdata[7] !== 1'b0; n++)
      rd_raw(8'hA1);
    chk(rdata, 8'h47);
    chk(rx, 8'hC3);
    chk(got, 8'h5A);
    $display("Master test done");
    wr_reg(8'hA1, 8'h00);
    spi_far_end_inst.pick(1'b0);
    repeat (4) @(negedge ref_clk);
    rd_reg(8'hA1, 8'h88);
    spi_far_end_inst.send(8'h96);
    spi_far_end_inst.pick(1'b1);
    repeat (6) @(negedge ref_clk);
    rd_reg(8'hA1, 8'h06);
    chk(rx, 8'h96);
    rx_read = 1'b1;
    @(negedge ref_clk);
    rx_read = 1'b0;
    rd_reg(8'hA1, 8'h07);
    $display("Slave test done");
    close_out();
  end
endmodule // spi_config_status_unit_test
bind spi_config_status_unit spi_cfg_props spi_cfg_props_inst (
  .REF_CLK(REF_CLK), .RESET(RESET), .SFR_ADDR(SFR_ADDR),
  .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .TX_WR(TX_WR),
  .TX_READY(TX_READY), .SCK_OE(SCK_OE), .MOSI_OE(MOSI_OE),
  .MISO_OE(MISO_OE), .SELECT_N(SELECT_N));
`default_nettype wire

// File: tb/spi_far_end.sv
// Purpose: Far serial device, master or slave
// Assumes: Clock mode 0
// Notes:   Clock stands still between frames
`timescale 1ns/100ps
`default_nettype none
module spi_far_end (
  input  wire logic       lclk,
  input  wire logic       sck_m,
  input  wire logic       mosi_m,
  output logic            sck,
  output logic            mosi,
  output logic            sel_n,
  output logic            miso,
  output logic      [7:0] got
);
  logic [7:0] ans = 8'hC3;
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
    sel_n = 1'b1;
    miso = 1'b1;
  end
  // Rotate so a released line never shows a stale level
  always @(negedge sck_m) begin
    ans <= {ans[6:0], ~ans[7]};
    miso <= ans[6];
  end
  always @(posedge sck_m) got <= {got[6:0], mosi_m};
  // Fresh answer per frame; config writes can toggle the clock
  task automatic load(input logic [7:0] a);
    ans = a;
    miso = a[7];
  endtask
  task automatic pick(input logic lvl);
    @(posedge lclk);
    sel_n <= lvl;
    mosi <= ~mosi;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge lclk);
      mosi <= b[i];
      @(posedge lclk);
      sck <= 1'b1;
      @(posedge lclk);
      sck <= 1'b0;
    end
  endtask
endmodule // spi_far_end
`default_nettype wire
